// *** tc8_clk_sel.v ***
`timescale 1ns/1ns
`include "tc8_defines.vh"

module tc8_clk_sel (
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire [2:0] cs_in,
  input  wire       ext_count_input_in,
  output reg        timer_tick_out
);

  reg  [`TC8_PRESC_W-1:0] presc;
  reg                     ext_meta;
  reg                     ext_sync;
  reg                     ext_prev;
  reg                     next_tick;

  // ----------------------------------------------------------------
  // prescaler and pin synchroniser
  // ----------------------------------------------------------------
  // prescaler free-runs so a source change does not restart the phase
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      presc    <= {`TC8_PRESC_W{1'b0}};
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      presc    <= presc + {{(`TC8_PRESC_W-1){1'b0}}, 1'b1};
      ext_meta <= ext_count_input_in;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // ----------------------------------------------------------------
  // source and edge select
  // ----------------------------------------------------------------
  always @* begin
    case (cs_in)
      `TC8_CS_STOP:     next_tick = 1'b0;
      `TC8_CS_DIV1:     next_tick = 1'b1;
      `TC8_CS_DIV8:     next_tick = (presc[2:0] == 3'h7);
      `TC8_CS_DIV64:    next_tick = (presc[5:0] == 6'h3f);
      `TC8_CS_DIV256:   next_tick = (presc[7:0] == 8'hff);
      `TC8_CS_DIV1024:  next_tick = (presc == 10'h3ff);
      `TC8_CS_EXT_FALL: next_tick = ext_prev & ~ext_sync;
      `TC8_CS_EXT_RISE: next_tick = ~ext_prev & ext_sync;
      default:          next_tick = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_tick_out <= 1'b0;
    end else begin
      timer_tick_out <= next_tick;
    end
  end

endmodule

// *** tc8_defines.vh ***
`ifndef TC8_DEFINES_VH
`define TC8_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TC8_OFF_CTRL_A      8'h00
`define TC8_OFF_CTRL_B      8'h04
`define TC8_OFF_COUNT       8'h08
`define TC8_OFF_CMP_A       8'h0c
`define TC8_OFF_CMP_B       8'h10
`define TC8_OFF_MASK        8'h14
`define TC8_OFF_FLAG        8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TC8_CA_COM_A_HI     7
`define TC8_CA_COM_A_LO     6
`define TC8_CA_COM_B_HI     5
`define TC8_CA_COM_B_LO     4
`define TC8_CA_MODE_HI      1
`define TC8_CA_MODE_LO      0
`define TC8_CB_FORCE_A      7
`define TC8_CB_FORCE_B      6
`define TC8_CB_MODE_2       3
`define TC8_CB_CS_HI        2
`define TC8_CB_CS_LO        0
`define TC8_FLAG_OVF        0
`define TC8_FLAG_MATCH_A    1
`define TC8_FLAG_MATCH_B    2

// ----------------------------------------------------------------
// reset values and fixed levels
// ----------------------------------------------------------------
`define TC8_RST_BYTE        8'h00
`define TC8_BOTTOM          8'h00
`define TC8_MAX             8'hff

// ----------------------------------------------------------------
// waveform modes
// ----------------------------------------------------------------
`define TC8_MODE_NORMAL     3'h0
`define TC8_MODE_PHASE_FF   3'h1
`define TC8_MODE_CTC        3'h2
`define TC8_MODE_FAST_FF    3'h3
`define TC8_MODE_PHASE_CMP  3'h5
`define TC8_MODE_FAST_CMP   3'h7

// ----------------------------------------------------------------
// clock source select codes and prescaler width
// ----------------------------------------------------------------
`define TC8_CS_STOP         3'h0
`define TC8_CS_DIV1         3'h1
`define TC8_CS_DIV8         3'h2
`define TC8_CS_DIV64        3'h3
`define TC8_CS_DIV256       3'h4
`define TC8_CS_DIV1024      3'h5
`define TC8_CS_EXT_FALL     3'h6
`define TC8_CS_EXT_RISE     3'h7
`define TC8_PRESC_W         10

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define TC8_RESP_OKAY       2'h0
`define TC8_RESP_SLVERR     2'h2

`endif

// *** tc8_pin_model.sv ***
`timescale 1ns/1ns
module tc8_pin_model (
  input  wire       clk_in,
  input  wire       go_in,
  input  wire [3:0] pulses_in,
  output reg        pin_out,
  output reg        busy_out
);
  reg [3:0] left;
  reg [1:0] ph;
  initial begin
    pin_out = 1'b0;
    busy_out = 1'b0;
  end
  // ----------------------------------------
  // pulse train
  // ----------------------------------------
  // slow pulses
  // four clocks a level so the synchroniser sees every edge
  always @(posedge clk_in) begin
    if (go_in && !busy_out) begin
      left <= pulses_in;
      busy_out <= 1'b1;
      ph <= 2'h0;
    end else if (busy_out) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        pin_out <= !pin_out;
        if (pin_out) left <= left - 4'h1;
        if (pin_out && left == 4'h1) busy_out <= 1'b0;
      end
    end
  end
endmodule

// *** tc8_timer.v ***
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tc8_defines.vh"

module tc8_timer (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        ext_count_input_in,
  input  wire [2:0]  irq_ack_in,
  output wire [2:0]  irq_req_out,
  output wire        wave_out_a_out,
  output wire        wave_out_a_oe_out,
  output wire        wave_out_b_out,
  output wire        wave_out_b_oe_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0]  ctrl_a;
  reg  [7:0]  timer_ctrl_b;
  reg  [7:0]  count_value;
  reg  [7:0]  compare_value_a;
  reg  [7:0]  compare_value_b;
  reg  [7:0]  active_cmp_a;
  reg  [7:0]  active_cmp_b;
  reg  [2:0]  timer_mask_reg;
  reg  [2:0]  timer_flag_reg;
  reg         count_down;
  reg         match_block;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [7:0]  w_data;
  reg         w_lane0;
  reg  [31:0] next_rdata;
  reg         next_rerr;
  reg  [7:0]  next_count;
  reg         next_down;
  wire        timer_tick;
  wire [2:0]  mode;
  wire [2:0]  clock_source_sel;
  wire        wr_fire;
  wire        wr_hit_count;
  wire        wr_hit_flag;
  wire        rd_fire;
  wire [7:0]  top_value;
  wire        at_top;
  wire        at_bottom;
  wire        match_a;
  wire        match_b;
  wire        match_ev_a;
  wire        match_ev_b;
  wire        ovf_ev;
  wire        fast_mode;
  wire        phase_mode;
  wire        pwm_mode;
  wire        force_a;
  wire        force_b;
  wire        wrap_ev;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  function is_fast;
    input [2:0] m;
    begin
      is_fast = (m == `TC8_MODE_FAST_FF) || (m == `TC8_MODE_FAST_CMP);
    end
  endfunction

  function is_phase;
    input [2:0] m;
    begin
      is_phase = (m == `TC8_MODE_PHASE_FF) || (m == `TC8_MODE_PHASE_CMP);
    end
  endfunction

  assign clock_source_sel = timer_ctrl_b[`TC8_CB_CS_HI:`TC8_CB_CS_LO];
  assign mode       = {timer_ctrl_b[`TC8_CB_MODE_2], ctrl_a[`TC8_CA_MODE_HI:`TC8_CA_MODE_LO]};
  assign fast_mode  = is_fast(mode);
  assign phase_mode = is_phase(mode);
  assign pwm_mode   = fast_mode | phase_mode;

  // ----------------------------------------------------------------
  // clock select
  // ----------------------------------------------------------------
  // internal or pin source
  tc8_clk_sel u_clk_sel (
    .clk_in             (clk_in),
    .rst_b_in           (rst_b_in),
    .cs_in              (clock_source_sel),
    .ext_count_input_in (ext_count_input_in),
    .timer_tick_out     (timer_tick)
  );

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // address and data in either order, each held until both in
  assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_held & ~s_axi_bvalid_out;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign wr_fire      = aw_held & w_held & ~s_axi_bvalid_out;
  assign rd_fire      = s_axi_arvalid_in & s_axi_arready_out;
  assign wr_hit_count = wr_fire & w_lane0 & (aw_addr == `TC8_OFF_COUNT);
  assign wr_hit_flag  = wr_fire & w_lane0 & (aw_addr == `TC8_OFF_FLAG);
  // force strobes act only in non-pwm modes and are never stored
  assign force_a = wr_fire & w_lane0 & (aw_addr == `TC8_OFF_CTRL_B) & w_data[`TC8_CB_FORCE_A] & ~pwm_mode;
  assign force_b = wr_fire & w_lane0 & (aw_addr == `TC8_OFF_CTRL_B) & w_data[`TC8_CB_FORCE_B] & ~pwm_mode;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= `TC8_RST_BYTE;
      w_data           <= `TC8_RST_BYTE;
      w_lane0          <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `TC8_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata_in[7:0];
        w_lane0 <= s_axi_wstrb_in[0];
      end
      if (wr_fire) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (aw_addr > `TC8_OFF_FLAG) ? `TC8_RESP_SLVERR : `TC8_RESP_OKAY;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case ({s_axi_araddr_in[7:2], 2'b00})
      `TC8_OFF_CTRL_A: next_rdata[7:0] = ctrl_a;
      `TC8_OFF_CTRL_B: next_rdata[7:0] = {2'b00, timer_ctrl_b[5:0]};
      `TC8_OFF_COUNT:  next_rdata[7:0] = count_value;
      `TC8_OFF_CMP_A:  next_rdata[7:0] = compare_value_a;
      `TC8_OFF_CMP_B:  next_rdata[7:0] = compare_value_b;
      `TC8_OFF_MASK:   next_rdata[2:0] = timer_mask_reg;
      `TC8_OFF_FLAG:   next_rdata[2:0] = timer_flag_reg;
      default:         next_rerr = 1'b1;
    endcase
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `TC8_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= next_rdata;
      s_axi_rresp_out  <= next_rerr ? `TC8_RESP_SLVERR : `TC8_RESP_OKAY;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control, compare buffers and masks
  // ----------------------------------------------------------------
  // reset clears state
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_a          <= `TC8_RST_BYTE;
      timer_ctrl_b    <= `TC8_RST_BYTE;
      compare_value_a <= `TC8_RST_BYTE;
      compare_value_b <= `TC8_RST_BYTE;
      timer_mask_reg  <= 3'h0;
    end else if (wr_fire && w_lane0) begin
      case (aw_addr)
        `TC8_OFF_CTRL_A: ctrl_a          <= w_data;
        `TC8_OFF_CTRL_B: timer_ctrl_b    <= {2'b00, w_data[5:0]};
        `TC8_OFF_CMP_A:  compare_value_a <= w_data;
        `TC8_OFF_CMP_B:  compare_value_b <= w_data;
        `TC8_OFF_MASK:   timer_mask_reg  <= w_data[2:0];
        default:         timer_mask_reg  <= timer_mask_reg;
      endcase
    end
  end

  // top is max or compare a
  assign top_value = (mode == `TC8_MODE_CTC || mode == `TC8_MODE_PHASE_CMP || mode == `TC8_MODE_FAST_CMP)
                     ? active_cmp_a : `TC8_MAX;
  assign at_top    = (count_value == top_value);
  assign at_bottom = (count_value == `TC8_BOTTOM);

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_cmp_a <= `TC8_RST_BYTE;
      active_cmp_b <= `TC8_RST_BYTE;
    end else if (!pwm_mode || (timer_tick && at_top)) begin
      active_cmp_a <= compare_value_a;
      active_cmp_b <= compare_value_b;
    end
  end

  // ----------------------------------------------------------------
  // counter unit
  // ----------------------------------------------------------------
  always @* begin
    next_count = count_value;
    next_down  = count_down;
    if (phase_mode) begin
      if (!count_down) begin
        if (at_top) begin
          next_down  = 1'b1;
          next_count = count_value - 8'h01;
        end else begin
          next_count = count_value + 8'h01;
        end
      end else if (at_bottom) begin
        next_down  = 1'b0;
        next_count = count_value + 8'h01;
      end else begin
        next_count = count_value - 8'h01;
      end
    end else begin
      next_down = 1'b0;
      if (at_top && mode != `TC8_MODE_NORMAL) begin
        next_count = `TC8_BOTTOM;
      end else begin
        next_count = count_value + 8'h01;
      end
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_value <= `TC8_RST_BYTE;
      count_down  <= 1'b0;
      match_block <= 1'b0;
    end else begin
      if (wr_hit_count) begin
        count_value <= w_data;
      end else if (timer_tick) begin
        count_value <= next_count;
        count_down  <= next_down;
      end
      // a counter write hides the match at the next tick, even when stopped
      if (wr_hit_count) begin
        match_block <= 1'b1;
      end else if (timer_tick) begin
        match_block <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare and flags
  // ----------------------------------------------------------------
  // continuous compare
  assign match_a    = (count_value == active_cmp_a);
  assign match_b    = (count_value == active_cmp_b);
  assign match_ev_a = timer_tick & match_a & ~match_block & ~wr_hit_count;
  assign match_ev_b = timer_tick & match_b & ~match_block & ~wr_hit_count;
  // top ends the count in fast pwm modes
  assign wrap_ev    = timer_tick & at_top & fast_mode & ~wr_hit_count;
  assign ovf_ev     = ~wr_hit_count & timer_tick &
                      (phase_mode ? (at_bottom & count_down) :
                       fast_mode  ? at_top : (count_value == `TC8_MAX));

  // clear by one or ack, set wins
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_flag_reg <= 3'h0;
    end else begin
      timer_flag_reg <= (timer_flag_reg & ~(irq_ack_in | ({3{wr_hit_flag}} & w_data[2:0])))
                        | {match_ev_b, match_ev_a, ovf_ev};
    end
  end

  assign irq_req_out = timer_flag_reg & timer_mask_reg;

  // ----------------------------------------------------------------
  // waveform generators
  // ----------------------------------------------------------------
  // waveform on compare pins
  tc8_wave u_wave_a (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .fast_in   (fast_mode),
    .phase_in  (phase_mode),
    .com_in    (ctrl_a[`TC8_CA_COM_A_HI:`TC8_CA_COM_A_LO]),
    .match_in  (match_ev_a),
    .force_in  (force_a),
    .bottom_in (wrap_ev),
    .down_in   (count_down),
    .wave_out  (wave_out_a_out)
  );

  tc8_wave u_wave_b (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .fast_in   (fast_mode),
    .phase_in  (phase_mode),
    .com_in    (ctrl_a[`TC8_CA_COM_B_HI:`TC8_CA_COM_B_LO]),
    .match_in  (match_ev_b),
    .force_in  (force_b),
    .bottom_in (wrap_ev),
    .down_in   (count_down),
    .wave_out  (wave_out_b_out)
  );

  // pin override follows compare output mode
  assign wave_out_a_oe_out = |ctrl_a[`TC8_CA_COM_A_HI:`TC8_CA_COM_A_LO];
  assign wave_out_b_oe_out = |ctrl_a[`TC8_CA_COM_B_HI:`TC8_CA_COM_B_LO];

endmodule

// *** tc8_timer_properties.sv ***
`timescale 1ns/1ns
`include "tc8_defines.vh"
module tc8_timer_properties (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire [7:0]  s_axi_awaddr_in,
  input wire        s_axi_awvalid_in,
  input wire        s_axi_awready_out,
  input wire        s_axi_wvalid_in,
  input wire        s_axi_wready_out,
  input wire [1:0]  s_axi_bresp_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in,
  input wire [7:0]  s_axi_araddr_in,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0]  s_axi_rresp_out,
  input wire        s_axi_rvalid_out,
  input wire        s_axi_rready_in,
  input wire [2:0]  irq_req_out,
  input wire        wave_out_a_out
);
  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire wr_go = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  wire rd_go = s_axi_arvalid_in && s_axi_arready_out;
  chk_wr_answer: assert property (wr_go |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write answer not on time");
  chk_wr_unmapped: assert property (wr_go && s_axi_awaddr_in > 8'h1b |-> ##2 s_axi_bresp_out == `TC8_RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write answer dropped");
  chk_b_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answering");
  chk_b_drop: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write answer repeated");
  chk_rd_answer: assert property (rd_go |=> s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h0)
    else $error("read answer wrong");
  chk_rd_unmapped: assert property (rd_go && s_axi_araddr_in > 8'h1b |=>
    s_axi_rresp_out == `TC8_RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped");
  chk_r_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answering");
  cov_write: cover property (wr_go);
  cov_read: cover property (rd_go);
  cov_irq: cover property (irq_req_out != 3'h0);
  cov_wave: cover property ($rose(wave_out_a_out));
endmodule
bind tc8_timer tc8_timer_properties u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .s_axi_awaddr_in(s_axi_awaddr_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .irq_req_out(irq_req_out),
  .wave_out_a_out(wave_out_a_out));

// *** tc8_timer_test.sv ***
`timescale 1ns/1ns
`include "tc8_defines.vh"
module tc8_timer_test;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  aw_addr = 8'h00;
  logic [7:0]  ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0;
  logic        aw_valid = 1'b0;
  logic        w_valid = 1'b0;
  logic        ar_valid = 1'b0, hs = 1'b0;
  logic        ext_go = 1'b0;
  logic [3:0]  ext_n = 4'h0;
  logic [2:0]  irq_ack = 3'h0;
  logic [33:0] bx;
  logic [33:0] exp_lo[$];
  logic [33:0] exp_hi[$];
  logic [1:0]  exp_b[$];
  wire         aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, ext_pin, ext_busy, wave_a, oe_a, wave_b, oe_b;
  wire [1:0]   b_resp, r_resp;
  wire [31:0]  r_data;
  wire [2:0]   irq_req;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          dv[4] = '{8, 64, 256, 1024};
  tc8_timer u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
    .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_valid),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid), .s_axi_bready_in(hs),
    .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid), .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_data),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid), .s_axi_rready_in(hs), .ext_count_input_in(ext_pin),
    .irq_ack_in(irq_ack), .irq_req_out(irq_req), .wave_out_a_out(wave_a), .wave_out_a_oe_out(oe_a),
    .wave_out_b_out(wave_b), .wave_out_b_oe_out(oe_b));
  tc8_pin_model u_pin (.clk_in(clk_in), .go_in(ext_go), .pulses_in(ext_n), .pin_out(ext_pin), .busy_out(ext_busy));
  initial forever #25 clk_in = ~clk_in;
  // ----------------------------------------
  // bus master and compares
  // ----------------------------------------
  function automatic logic [33:0] ok8(input logic [7:0] v);
    return {26'h0, v};
  endfunction
  task cmp(input string nm, input logic [33:0] lo, input logic [33:0] hi, input logic [33:0] got);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  task pin(input string nm, input logic e, input logic got);
    @(negedge clk_in);
    cmp(nm, {33'h0, e}, {33'h0, e}, {33'h0, got});
    @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    exp_b.push_back(a > 8'h1b ? `TC8_RESP_SLVERR : `TC8_RESP_OKAY);
    aw_addr <= a;
    w_data <= {24'h0, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    do begin
      @(posedge clk_in);
      if (aw_rdy) aw_valid <= 1'b0;
      if (w_rdy) w_valid <= 1'b0;
    end while ((aw_valid && !aw_rdy) || (w_valid && !w_rdy));
    do @(posedge clk_in); while (!(b_valid && hs));
  endtask
  task rd(input logic [7:0] a, input logic [33:0] lo, input logic [33:0] hi);
    exp_lo.push_back(lo);
    exp_hi.push_back(hi);
    ar_addr <= a;
    ar_valid <= 1'b1;
    do @(posedge clk_in); while (!ar_rdy);
    ar_valid <= 1'b0;
    do @(posedge clk_in); while (!(r_valid && hs));
  endtask
  always @(posedge clk_in) begin
    if (b_valid | r_valid) hs <= !hs;
    if (r_valid && hs) cmp("rdata", exp_lo.pop_front(), exp_hi.pop_front(), {r_resp, r_data});
    if (b_valid && hs) begin
      bx = {32'h0, exp_b.pop_front()};
      cmp("bresp", bx, bx, {32'h0, b_resp});
    end
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] a;
    v = $urandom(32'he58c);
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    for (a = 8'h00; a <= 8'h18; a = a + 8'h04) rd(a, ok8(8'h00), ok8(8'h00));
    rd(8'h1c, {`TC8_RESP_SLVERR, 32'h0}, {`TC8_RESP_SLVERR, 32'h0});
    pin("oe_a", 1'b0, oe_a);
    $display("test reset done");
    for (a = `TC8_OFF_COUNT; a <= `TC8_OFF_CMP_B; a = a + 8'h04) begin
      v = $urandom;
      wr(a, v);
      rd(a, ok8(v), ok8(v));
    end
    v = $urandom;
    wr(`TC8_OFF_MASK, v);
    rd(`TC8_OFF_MASK, ok8(v & 8'h07), ok8(v & 8'h07));
    wr(8'h1c, v);
    wr(`TC8_OFF_MASK, 8'h00);
    wr(`TC8_OFF_COUNT, 8'h5a);
    repeat (20) @(posedge clk_in);
    rd(`TC8_OFF_COUNT, ok8(8'h5a), ok8(8'h5a));
    $display("test access done");
    wr(`TC8_OFF_CMP_A, 8'hf8);
    wr(`TC8_OFF_CMP_B, 8'hfc);
    wr(`TC8_OFF_COUNT, 8'hf0);
    wr(`TC8_OFF_CTRL_B, {5'h0, `TC8_CS_DIV1});
    repeat (40) @(posedge clk_in);
    wr(`TC8_OFF_CTRL_B, 8'h00);
    rd(`TC8_OFF_FLAG, ok8(8'h07), ok8(8'h07));
    pin("irq0", 1'b0, irq_req[1]);
    wr(`TC8_OFF_MASK, 8'h02);
    pin("irq1", 1'b1, irq_req[1]);
    wr(`TC8_OFF_FLAG, 8'h02);
    rd(`TC8_OFF_FLAG, ok8(8'h05), ok8(8'h05));
    pin("irq2", 1'b0, irq_req[1]);
    irq_ack <= 3'b001;
    @(posedge clk_in);
    irq_ack <= 3'b000;
    rd(`TC8_OFF_FLAG, ok8(8'h04), ok8(8'h04));
    wr(`TC8_OFF_FLAG, 8'h04);
    $display("test flags done");
    for (int k = 0; k < 4; k++) begin
      wr(`TC8_OFF_COUNT, 8'h00);
      wr(`TC8_OFF_CTRL_B, 8'(k + 2));
      repeat (4 * dv[k] - 3) @(posedge clk_in);
      wr(`TC8_OFF_CTRL_B, 8'h00);
      rd(`TC8_OFF_COUNT, ok8(8'h03), ok8(8'h05));
    end
    for (v = 8'h06; v <= 8'h07; v++) begin
      wr(`TC8_OFF_COUNT, 8'h00);
      wr(`TC8_OFF_CTRL_B, v);
      repeat (8) @(posedge clk_in);
      ext_n <= v[3:0];
      ext_go <= 1'b1;
      @(posedge clk_in);
      ext_go <= 1'b0;
      @(posedge clk_in);
      while (ext_busy) @(posedge clk_in);
      repeat (8) @(posedge clk_in);
      wr(`TC8_OFF_CTRL_B, 8'h00);
      rd(`TC8_OFF_COUNT, ok8(v), ok8(v));
    end
    $display("test clocks done");
    wr(`TC8_OFF_CTRL_A, {6'h0, 2'h2});
    wr(`TC8_OFF_CMP_A, 8'h09);
    wr(`TC8_OFF_CMP_B, 8'h40);
    wr(`TC8_OFF_COUNT, 8'h00);
    wr(`TC8_OFF_CTRL_B, {5'h0, `TC8_CS_DIV1});
    repeat (50) @(posedge clk_in);
    wr(`TC8_OFF_CTRL_B, 8'h00);
    rd(`TC8_OFF_COUNT, ok8(8'h00), ok8(8'h09));
    rd(`TC8_OFF_FLAG, ok8(8'h02), ok8(8'h02));
    wr(`TC8_OFF_FLAG, 8'h07);
    wr(`TC8_OFF_CTRL_A, 8'hf0);
    wr(`TC8_OFF_CTRL_B, 8'hc0);
    pin("wave_a", 1'b1, wave_a);
    pin("wave_b", 1'b1, wave_b & oe_b);
    wr(`TC8_OFF_CTRL_A, 8'h80);
    wr(`TC8_OFF_CTRL_B, 8'h80);
    pin("wave_a", 1'b0, wave_a);
    $display("test compare done");
    wr(`TC8_OFF_CTRL_A, {6'h0, 2'h1});
    wr(`TC8_OFF_COUNT, 8'h00);
    wr(`TC8_OFF_CTRL_B, {5'h0, `TC8_CS_DIV1});
    repeat (297) @(posedge clk_in);
    wr(`TC8_OFF_CTRL_B, 8'h00);
    rd(`TC8_OFF_COUNT, ok8(8'd200), ok8(8'd220));
    wr(`TC8_OFF_CTRL_A, 8'h00);
    wr(`TC8_OFF_CTRL_B, {5'h0, `TC8_CS_DIV1});
    repeat (10) @(posedge clk_in);
    wr(`TC8_OFF_COUNT, 8'h80);
    wr(`TC8_OFF_CTRL_B, 8'h00);
    rd(`TC8_OFF_COUNT, ok8(8'h80), ok8(8'h85));
    $display("test modes done");
    stop_test();
  end
endmodule

// *** tc8_wave.v ***
`timescale 1ns/1ns
`include "tc8_defines.vh"

module tc8_wave (
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire       fast_in,
  input  wire       phase_in,
  input  wire [1:0] com_in,
  input  wire       match_in,
  input  wire       force_in,
  input  wire       bottom_in,
  input  wire       down_in,
  output reg        wave_out
);

  reg next_wave;

  // ----------------------------------------------------------------
  // output compare state
  // ----------------------------------------------------------------
  always @* begin
    next_wave = wave_out;
    if (fast_in) begin
      if (match_in && com_in[1]) begin
        next_wave = com_in[0];
      end else if (bottom_in && com_in[1]) begin
        next_wave = ~com_in[0];
      end
    end else if (phase_in) begin
      if (match_in && com_in[1]) begin
        next_wave = com_in[0] ^ down_in;
      end
    end else if (match_in || force_in) begin
      case (com_in)
        2'h1:    next_wave = ~wave_out;
        2'h2:    next_wave = 1'b0;
        2'h3:    next_wave = 1'b1;
        default: next_wave = wave_out;
      endcase
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wave_out <= 1'b0;
    end else begin
      wave_out <= next_wave;
    end
  end

endmodule
